// [pkg/jisp_pkg.sv]
package jisp_pkg;
   // ********
   // Register map on the Wishbone slave
   // ********
   localparam int WB_ADR_W = 8;
   localparam logic [7:0] OFS_PORT_ENABLE = 8'h00;
   localparam logic [7:0] OFS_STATUS = 8'h04;
   localparam int ENABLE_BIT = 0;
   localparam logic RST_ENABLE = 1'h0;

   // Status word field positions
   localparam int ST_SECURITY = 0;
   localparam int ST_ERROR = 1;
   localparam int ST_JTAG_ON = 2;
   localparam int ST_CHANNEL = 3;
   localparam int ST_EXT = 4;
   localparam int ST_ISC_OFF = 5;
   localparam int ST_OPEN_DRAIN = 6;
   localparam int ST_BUSY = 7;

   // ********
   // Serial link: instruction codes and register widths
   // ********
   localparam int IR_W = 4;
   localparam int DR_W = 24;
   localparam int ADDR_W = 16;
   localparam int DATA_W = 8;
   localparam logic [3:0] IR_CAPTURE = 4'h1;
   localparam logic [3:0] INS_ISC_ENABLE = 4'h2;
   localparam logic [3:0] INS_EXT_ENABLE = 4'h3;
   localparam logic [3:0] INS_OPEN_DRAIN = 4'h4;
   localparam logic [3:0] INS_CLR_ERROR = 4'h5;
   localparam logic [3:0] INS_ISC_DISABLE = 4'h6;
   localparam logic [3:0] INS_PROGRAM = 4'h8;
   localparam logic [3:0] INS_SECT_ERASE = 4'h9;
   localparam logic [3:0] INS_CHIP_ERASE = 4'hA;
   localparam logic [3:0] INS_READ = 4'hB;
   localparam logic [3:0] INS_VERIFY = 4'hC;
   localparam logic [3:0] INS_BYPASS = 4'hF;

   // ********
   // Flash sectors and flash operations
   // ********
   localparam int NUM_SECT = 12;
   localparam int SECT_W = 4;
   localparam int SECT_LSB = 12;
   localparam logic [1:0] FOP_PROGRAM = 2'h0;
   localparam logic [1:0] FOP_SECT_ERASE = 2'h1;
   localparam logic [1:0] FOP_CHIP_ERASE = 2'h2;
   localparam logic [1:0] FOP_READ = 2'h3;

   // Pins passed through the synchroniser
   localparam int SYNC_W = 5;
   localparam logic [4:0] SYNC_RST = 5'h0A;

   typedef enum logic [3:0] {
      JISP_TLR, JISP_IDLE, JISP_SEL_DR, JISP_CAP_DR, JISP_SHIFT_DR, JISP_EXIT1_DR,
      JISP_PAUSE_DR, JISP_EXIT2_DR, JISP_UPD_DR, JISP_SEL_IR, JISP_CAP_IR,
      JISP_SHIFT_IR, JISP_EXIT1_IR, JISP_PAUSE_IR, JISP_EXIT2_IR, JISP_UPD_IR
   } jisp_tap_t;
endpackage : jisp_pkg

// [verilog/jisp_sync.sv]
module jisp_sync (
   input wire logic clock,
   input wire logic rst,
   input wire logic [jisp_pkg::SYNC_W-1:0] async_in,
   output logic [jisp_pkg::SYNC_W-1:0] stable
);
   import jisp_pkg::*;

   logic [SYNC_W-1:0] ff1;
   logic [SYNC_W-1:0] ff2;
   logic [SYNC_W-1:0] ff3;
   logic [SYNC_W-1:0] agree;

   // ****************************************************************
   // Three-stage capture; the first stage feeds only the second
   // ****************************************************************
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         ff1 <= SYNC_RST;
         ff2 <= SYNC_RST;
         ff3 <= SYNC_RST;
      end else begin
         ff1 <= async_in;
         ff2 <= ff1;
         ff3 <= ff2;
      end
   end

   // A bit moves only when stages two and three agree, filtering one-cycle glitches
   assign agree = ~(ff2 ^ ff3);

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         stable <= SYNC_RST;
      end else begin
         stable <= (ff3 & agree) | (stable & ~agree);
      end
   end
endmodule : jisp_sync

// [verilog/jisp_port.sv]
// What this block does
// - Dedicated pins ignore device reset entirely
// - Register-only enable: reset blocks, aborts operations
// - Programming instructions only, no boundary scan
// - Status pins activate only after enable command
// - Failed program or erase sets error low
// - Error holds until clear command or reset-after-disable
// - Status pin high ready, low while busy
// - Command selects open-drain for both status pins
// - Security bit blocks every memory read
// - Security allows only full chip erase
// - Chip erase clears security bit too
// - Protected sectors refuse sector erase; chip erase ignores protection
// - Pins claimed by dedicate, enable bit, or term
// - Enable bit 0, cleared by reset or write
// - Data out driven only after enable command
//
// Decided for this implementation: the Wishbone slave port and the placing of the registers.
module jisp_port (
   input wire logic clock,
   input wire logic rst,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [jisp_pkg::WB_ADR_W-1:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   input wire logic tck,
   input wire logic tms,
   input wire logic tdi,
   output logic tdo_out,
   output logic tdo_oe_n,
   input wire logic device_reset_n,
   input wire logic pin_claim_product_term,
   input wire logic nv_dedicate,
   input wire logic nv_security,
   input wire logic [jisp_pkg::NUM_SECT-1:0] nv_sector_protect,
   output logic jtag_pins_claimed,
   output logic ext_pins_claimed,
   output logic flash_status_pin_out,
   output logic flash_status_pin_oe_n,
   output logic program_error_flag_pin_out,
   output logic program_error_flag_pin_oe_n,
   output logic flash_start,
   output logic [1:0] flash_op,
   output logic [jisp_pkg::ADDR_W-1:0] flash_addr,
   output logic [jisp_pkg::DATA_W-1:0] flash_wdata,
   output logic flash_abort,
   input wire logic flash_busy,
   input wire logic flash_done,
   input wire logic flash_fail,
   input wire logic [jisp_pkg::DATA_W-1:0] flash_rdata
);
   import jisp_pkg::*;

   // ********
   // Pin synchronisation and edge detection
   // ********
   logic [SYNC_W-1:0] pins_s;
   logic tck_s;
   logic tms_s;
   logic tdi_s;
   logic dev_rst_n_s;
   logic term_s;
   logic tck_prev;
   logic dev_rst_prev;
   wire tck_rise;
   wire tck_fall;
   wire dev_rst;
   wire dev_rst_release;

   jisp_sync u_sync (
      .clock(clock),
      .rst(rst),
      .async_in({pin_claim_product_term, device_reset_n, tdi, tms, tck}),
      .stable(pins_s)
   );

   assign tck_s = pins_s[0];
   assign tms_s = pins_s[1];
   assign tdi_s = pins_s[2];
   assign dev_rst_n_s = pins_s[3];
   assign term_s = pins_s[4];

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         tck_prev <= 1'h0;
         dev_rst_prev <= 1'h0;
      end else begin
         tck_prev <= tck_s;
         dev_rst_prev <= dev_rst;
      end
   end

   assign tck_rise = tck_s & ~tck_prev;
   assign tck_fall = ~tck_s & tck_prev;
   assign dev_rst = ~dev_rst_n_s;
   assign dev_rst_release = dev_rst_prev & ~dev_rst;

   // ********
   // Pin claim and reset blocking
   // ********
   logic enable_bit;
   logic security;
   logic sec_loaded;
   wire jtag_on;
   wire blocked;

   assign jtag_on = nv_dedicate | enable_bit | term_s;
   // Reset only bites when the register bit is the sole claim; dedicated pins ignore it
   assign blocked = dev_rst & ~nv_dedicate & ~term_s;

   // ********
   // Wishbone slave
   // ********
   wire wb_req;
   wire hit_enable;
   wire hit_status;
   wire wr_enable;
   logic [31:0] status_word;
   logic [31:0] next_rdata;

   assign wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
   assign hit_enable = wb_adr_i == OFS_PORT_ENABLE;
   assign hit_status = wb_adr_i == OFS_STATUS;
   assign wr_enable = wb_req & wb_we_i & hit_enable & wb_sel_i[0];

   // Unmapped addresses still ack, reading zero, so a stray access never hangs the bus
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         wb_ack_o <= 1'h0;
         wb_dat_o <= 32'h00000000;
      end else begin
         wb_ack_o <= wb_req;
         wb_dat_o <= next_rdata;
      end
   end

   // Device reset clears the enable bit even if a write lands in the same cycle
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         enable_bit <= RST_ENABLE;
      end else if (dev_rst) begin
         enable_bit <= 1'h0;
      end else if (wr_enable) begin
         enable_bit <= wb_dat_i[ENABLE_BIT];
      end
   end

   // ********
   // Test access port state machine
   // ********
   jisp_tap_t tap;
   jisp_tap_t next_tap;
   logic [IR_W-1:0] ir;
   logic [IR_W-1:0] ir_shift;
   logic [DR_W-1:0] dr;
   logic bypass_bit;
   logic channel_on;
   logic ext_on;
   logic open_drain;
   logic isc_disabled;
   logic error_flag;

   always_comb begin
      next_tap = tap;
      unique case (tap)
         JISP_TLR: next_tap = tms_s ? JISP_TLR : JISP_IDLE;
         JISP_IDLE: next_tap = tms_s ? JISP_SEL_DR : JISP_IDLE;
         JISP_SEL_DR: next_tap = tms_s ? JISP_SEL_IR : JISP_CAP_DR;
         JISP_CAP_DR: next_tap = tms_s ? JISP_EXIT1_DR : JISP_SHIFT_DR;
         JISP_SHIFT_DR: next_tap = tms_s ? JISP_EXIT1_DR : JISP_SHIFT_DR;
         JISP_EXIT1_DR: next_tap = tms_s ? JISP_UPD_DR : JISP_PAUSE_DR;
         JISP_PAUSE_DR: next_tap = tms_s ? JISP_EXIT2_DR : JISP_PAUSE_DR;
         JISP_EXIT2_DR: next_tap = tms_s ? JISP_UPD_DR : JISP_SHIFT_DR;
         JISP_UPD_DR: next_tap = tms_s ? JISP_SEL_DR : JISP_IDLE;
         JISP_SEL_IR: next_tap = tms_s ? JISP_TLR : JISP_CAP_IR;
         JISP_CAP_IR: next_tap = tms_s ? JISP_EXIT1_IR : JISP_SHIFT_IR;
         JISP_SHIFT_IR: next_tap = tms_s ? JISP_EXIT1_IR : JISP_SHIFT_IR;
         JISP_EXIT1_IR: next_tap = tms_s ? JISP_UPD_IR : JISP_PAUSE_IR;
         JISP_PAUSE_IR: next_tap = tms_s ? JISP_EXIT2_IR : JISP_PAUSE_IR;
         JISP_EXIT2_IR: next_tap = tms_s ? JISP_UPD_IR : JISP_SHIFT_IR;
         JISP_UPD_IR: next_tap = tms_s ? JISP_SEL_DR : JISP_IDLE;
      endcase
   end

   // Link steps on each rising test clock; a blocking reset holds it in reset state
   wire tap_live;
   assign tap_live = jtag_on & ~blocked;

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         tap <= JISP_TLR;
      end else if (!tap_live) begin
         tap <= JISP_TLR;
      end else if (tck_rise) begin
         tap <= next_tap;
      end
   end

   // ********
   // Instruction decode and command gating
   // ********
   wire step;
   wire upd_ir;
   wire upd_dr;
   wire cap_dr;
   wire is_read;
   wire is_known;
   wire [SECT_W-1:0] sector;
   wire sect_locked;
   wire do_program;
   wire do_serase;
   wire do_cerase;
   wire do_read;
   wire flash_cmd;
   logic op_active;
   logic [1:0] active_op;

   // Sector index beyond the array counts as locked, so a bad address erases nothing
   function automatic logic sector_locked(input logic [SECT_W-1:0] idx,
                                         input logic [NUM_SECT-1:0] prot);
      if (idx >= SECT_W'(NUM_SECT)) begin
         return 1'h1;
      end
      return prot[idx];
   endfunction : sector_locked

   assign step = tck_rise & tap_live;
   assign upd_ir = step & (tap == JISP_UPD_IR);
   assign upd_dr = step & (tap == JISP_UPD_DR) & channel_on & ~op_active;
   assign cap_dr = step & (tap == JISP_CAP_DR);
   assign is_read = (ir == INS_READ) | (ir == INS_VERIFY);
   // Boundary-scan and other unlisted codes fall into the one-bit bypass path
   assign is_known = (ir == INS_PROGRAM) | (ir == INS_SECT_ERASE) | (ir == INS_CHIP_ERASE)
                     | is_read;
   assign sector = dr[DATA_W+SECT_LSB +: SECT_W]; // Top nibble of the address field
   assign sect_locked = sector_locked(sector, nv_sector_protect);
   assign do_program = upd_dr & (ir == INS_PROGRAM) & ~security;
   assign do_serase = upd_dr & (ir == INS_SECT_ERASE) & ~security & ~sect_locked;
   assign do_cerase = upd_dr & (ir == INS_CHIP_ERASE);
   assign do_read = upd_dr & is_read & ~security;
   assign flash_cmd = do_program | do_serase | do_cerase | do_read;

   // ********
   // Instruction and data shift paths
   // ********
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         ir <= INS_BYPASS;
         ir_shift <= INS_BYPASS;
      end else if (!tap_live || (tck_rise && tap == JISP_TLR)) begin
         ir <= INS_BYPASS;
      end else if (step) begin
         if (tap == JISP_CAP_IR) begin
            ir_shift <= IR_CAPTURE;
         end else if (tap == JISP_SHIFT_IR) begin
            ir_shift <= {tdi_s, ir_shift[IR_W-1:1]};
         end else if (tap == JISP_UPD_IR) begin
            ir <= ir_shift;
         end
      end
   end

   // Read data is replaced by zero under security so nothing leaks through the shift path
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         dr <= '0;
         bypass_bit <= 1'h0;
      end else if (cap_dr) begin
         bypass_bit <= 1'h0;
         if (is_read) begin
            dr <= {dr[DR_W-1:DATA_W], security ? 8'h00 : flash_rdata};
         end
      end else if (step && tap == JISP_SHIFT_DR) begin
         if (is_known) begin
            dr <= {tdi_s, dr[DR_W-1:1]};
         end else begin
            bypass_bit <= tdi_s;
         end
      end
   end

   // Output bit changes on the falling test clock, as the far end samples on rising
   wire shift_bit;
   assign shift_bit = (tap == JISP_SHIFT_IR) ? ir_shift[0] : (is_known ? dr[0] : bypass_bit);

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         tdo_out <= 1'h0;
         tdo_oe_n <= 1'h1;
      end else begin
         if (tck_fall) begin
            tdo_out <= shift_bit;
         end
         tdo_oe_n <= ~(channel_on & tap_live);
      end
   end

   // ********
   // Session modes set by instructions
   // ********
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         channel_on <= 1'h0;
         ext_on <= 1'h0;
         open_drain <= 1'h0;
         isc_disabled <= 1'h0;
      end else if (!tap_live) begin
         channel_on <= 1'h0;
         ext_on <= 1'h0;
      end else if (upd_ir) begin
         if (ir_shift == INS_ISC_ENABLE || ir_shift == INS_EXT_ENABLE) begin
            channel_on <= 1'h1;
            isc_disabled <= 1'h0;
         end
         if (ir_shift == INS_EXT_ENABLE) begin
            ext_on <= 1'h1;
         end
         if (ir_shift == INS_OPEN_DRAIN && channel_on) begin
            open_drain <= 1'h1;
         end
         if (ir_shift == INS_ISC_DISABLE) begin
            channel_on <= 1'h0;
            ext_on <= 1'h0;
            isc_disabled <= 1'h1;
         end
      end else if (dev_rst_release) begin
         isc_disabled <= 1'h0;
      end
   end

   // ********
   // Flash operation launch, completion and abort
   // ********
   wire [1:0] next_op;
   assign next_op = do_program ? FOP_PROGRAM : do_serase ? FOP_SECT_ERASE :
                    do_cerase ? FOP_CHIP_ERASE : FOP_READ;
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         flash_start <= 1'h0;
         flash_op <= FOP_READ;
         flash_addr <= '0;
         flash_wdata <= '0;
         flash_abort <= 1'h0;
         op_active <= 1'h0;
         active_op <= FOP_READ;
      end else begin
         flash_start <= flash_cmd;
         flash_abort <= blocked & op_active;
         if (flash_cmd) begin
            flash_op <= next_op;
            active_op <= next_op;
            flash_addr <= dr[DR_W-1:DATA_W];
            flash_wdata <= dr[DATA_W-1:0];
            op_active <= 1'h1;
         end else if (flash_done || (blocked && op_active)) begin
            op_active <= 1'h0;
         end
      end
   end

   // ********
   // Security bit and error flag
   // ********
   wire wr_fail;
   wire err_clear;
   assign wr_fail = flash_done & flash_fail & op_active & (active_op != FOP_READ);
   assign err_clear = (upd_ir & (ir_shift == INS_CLR_ERROR)) | (isc_disabled & dev_rst_release);

   // Security strap is caught one cycle after reset release, never inside the reset
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         security <= 1'h1;
         sec_loaded <= 1'h0;
      end else if (!sec_loaded) begin
         security <= nv_security;
         sec_loaded <= 1'h1;
      end else if (flash_done && !flash_fail && op_active && active_op == FOP_CHIP_ERASE) begin
         security <= 1'h0;
      end
   end

   // A failure landing in the clearing cycle wins, so no error is ever missed
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         error_flag <= 1'h0;
      end else if (wr_fail) begin
         error_flag <= 1'h1;
      end else if (err_clear) begin
         error_flag <= 1'h0;
      end
   end

   // ********
   // Extension pins and claim outputs
   // ********
   logic next_stat_oe_n;
   logic next_err_oe_n;
   wire stat_level;
   wire err_level;
   assign stat_level = ~flash_busy;
   assign err_level = ~error_flag;

   // Open-drain releases the pin for a high, so an external pull-up sets the level
   always_comb begin
      next_stat_oe_n = 1'h1;
      next_err_oe_n = 1'h1;
      if (ext_on && tap_live) begin
         next_stat_oe_n = open_drain ? stat_level : 1'h0;
         next_err_oe_n = open_drain ? err_level : 1'h0;
      end
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         flash_status_pin_out <= 1'h1;
         flash_status_pin_oe_n <= 1'h1;
         program_error_flag_pin_out <= 1'h1;
         program_error_flag_pin_oe_n <= 1'h1;
         jtag_pins_claimed <= 1'h0;
         ext_pins_claimed <= 1'h0;
      end else begin
         flash_status_pin_out <= stat_level;
         flash_status_pin_oe_n <= next_stat_oe_n;
         program_error_flag_pin_out <= err_level;
         program_error_flag_pin_oe_n <= next_err_oe_n;
         jtag_pins_claimed <= jtag_on;
         ext_pins_claimed <= ext_on & tap_live;
      end
   end

   // ********
   // Read-back of block state
   // ********
   always_comb begin
      status_word = 32'h00000000;
      status_word[ST_SECURITY] = security;
      status_word[ST_ERROR] = error_flag;
      status_word[ST_JTAG_ON] = jtag_on;
      status_word[ST_CHANNEL] = channel_on;
      status_word[ST_EXT] = ext_on;
      status_word[ST_ISC_OFF] = isc_disabled;
      status_word[ST_OPEN_DRAIN] = open_drain;
      status_word[ST_BUSY] = op_active;
      next_rdata = 32'h00000000;
      if (wb_req && !wb_we_i && hit_enable) begin
         next_rdata[ENABLE_BIT] = enable_bit;
      end else if (wb_req && !wb_we_i && hit_status) begin
         next_rdata = status_word;
      end
   end
endmodule : jisp_port

// [sim/jisp_properties.sv]
module jisp_properties
   import jisp_pkg::*;
(
   input wire logic clock,
   input wire logic rst,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_ack_o,
   input wire logic device_reset_n,
   input wire logic pin_claim_product_term,
   input wire logic nv_dedicate,
   input wire logic [jisp_pkg::NUM_SECT-1:0] nv_sector_protect,
   input wire logic jtag_pins_claimed,
   input wire logic ext_pins_claimed,
   input wire logic tdo_oe_n,
   input wire logic flash_status_pin_out,
   input wire logic flash_status_pin_oe_n,
   input wire logic program_error_flag_pin_out,
   input wire logic program_error_flag_pin_oe_n,
   input wire logic flash_start,
   input wire logic [1:0] flash_op,
   input wire logic [jisp_pkg::ADDR_W-1:0] flash_addr,
   input wire logic flash_busy
);
   // ********
   // Port checks
   // ********
   logic blk;
   // Nothing but the enable bit claims the pins, and device reset is low
   assign blk = !device_reset_n && !nv_dedicate && !pin_claim_product_term;
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (rst);
   AST_ACK_NEXT: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
      else $error("no ack after request");
   AST_ACK_ONE: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack held too long");
   AST_CLAIM_DEDICATE: assert property (nv_dedicate |=> jtag_pins_claimed)
      else $error("dedicated pins not claimed");
   // Eight cycles cover the synchroniser and the late claim output
   AST_RESET_BLOCKS: assert property (blk [*8] |-> !jtag_pins_claimed && tdo_oe_n)
      else $error("pins kept under device reset");
   AST_TDO_OE: assert property (!tdo_oe_n |-> jtag_pins_claimed ||
      $past(jtag_pins_claimed)) else $error("data out driven while unclaimed");
   AST_EXT_IDLE: assert property (!ext_pins_claimed && !$past(ext_pins_claimed) |->
      flash_status_pin_oe_n && program_error_flag_pin_oe_n)
      else $error("status pins driven early");
   AST_STATUS_PIN: assert property (!$past(rst) |->
      flash_status_pin_out == !$past(flash_busy)) else $error("status pin not ready level");
   AST_SECT_PROTECT: assert property (flash_start && flash_op == FOP_SECT_ERASE |->
      flash_addr[SECT_LSB+:SECT_W] < 4'hC && !nv_sector_protect[flash_addr[SECT_LSB+:SECT_W]])
      else $error("erase started on protected sector");
   // Main scenarios reached
   COV_START: cover property (flash_start);
   COV_EXT: cover property (ext_pins_claimed);
   COV_ERROR: cover property (!program_error_flag_pin_out);
endmodule : jisp_properties

// [sim/jisp_jtag_model.sv]
module jisp_jtag_model (
   output logic tck,
   output logic tms,
   output logic tdi,
   input wire logic tdo
);
   timeunit 1ns;
   timeprecision 100ps;
   // ********
   // Link controller
   // ********
   // Link clock stands low between frames
   initial begin
      tck = 1'h0;
      tms = 1'h1;
      tdi = 1'h0;
   end
   // One 48 ns clock; data out is taken late, after the device has settled it
   task automatic step(input logic m, input logic d, output logic o);
      tms = m;
      tdi = d;
      #24;
      o = tdo;
      tck = 1'h1;
      #24;
      tck = 1'h0;
   endtask : step
   task automatic tlr;
      logic o;
      repeat (5) step(1'h1, 1'h0, o);
      step(1'h0, 1'h0, o);
   endtask : tlr
   // Idle to shift, n bits LSB first, update, back to Idle; commands go this way
   task automatic scan(input logic ir, input logic [23:0] v, input int n, output logic [23:0] q);
      logic o;
      q = 24'h0;
      step(1'h1, 1'h0, o);
      if (ir) step(1'h1, 1'h0, o);
      step(1'h0, 1'h0, o);
      step(1'h0, 1'h0, o);
      for (int i = 0; i < n; i++) begin
         step(i == n - 1, v[i], o);
         q[i] = o;
      end
      step(1'h1, 1'h0, o);
      step(1'h0, ~v[0], o);
   endtask : scan
endmodule : jisp_jtag_model

// [sim/tb.sv]
module tb;
   timeunit 1ns;
   timeprecision 100ps;
   import jisp_pkg::*;
   localparam logic [3:0] BLOCKED [4] = '{INS_READ, INS_VERIFY, INS_PROGRAM, INS_SECT_ERASE};
   logic clock = 1'h0, rst = 1'h1, wb_cyc_i = 1'h0, wb_stb_i = 1'h0, wb_we_i = 1'h0;
   logic [7:0] wb_adr_i = 8'h00, flash_rdata = 8'h5A, flash_wdata;
   logic [3:0] wb_sel_i = 4'hF;
   logic [31:0] wb_dat_i = 32'h0, wb_dat_o, q;
   logic device_reset_n = 1'h1, pin_claim_product_term = 1'h0, nv_dedicate = 1'h0;
   logic nv_security = 1'h0, flash_busy = 1'h0, flash_done = 1'h0, flash_fail = 1'h0;
   logic [11:0] nv_sector_protect = 12'h004;
   logic tck, tms, tdi, tdo, tdo_out, tdo_oe_n, wb_ack_o, jtag_pins_claimed, ext_pins_claimed;
   logic flash_status_pin_out, flash_status_pin_oe_n, flash_start, flash_abort, fail_next = 1'h0;
   logic program_error_flag_pin_out, program_error_flag_pin_oe_n;
   logic [1:0] flash_op;
   logic [15:0] flash_addr;
   logic [23:0] r;
   int fail_count = 0, comparisons = 0, starts = 0, fcnt = 0, s0 = 0;
   // Released data line shows the inverse, never a friendly stale value
   assign tdo = tdo_oe_n ? ~tdo_out : tdo_out;
   jisp_port jisp_port_inst (.*);
   jisp_jtag_model jisp_jtag_model_inst (.*);
   always #2 clock = ~clock;
   // Flash array: busy for six cycles per start, then done with the chosen outcome
   always @(posedge clock) begin
      flash_done <= 1'h0;
      if (flash_start) begin
         starts <= starts + 1;
         flash_busy <= 1'h1;
         fcnt <= 6;
      end else if (fcnt == 1) begin
         flash_busy <= 1'h0;
         flash_done <= 1'h1;
         flash_fail <= fail_next;
         fcnt <= 0;
      end else if (fcnt > 0) begin
         fcnt <= fcnt - 1;
      end
   end
   // Hang guard, well above the length of the sequence
   initial begin
      repeat (40000) @(posedge clock);
      fail_count++;
      wrap_up();
   end
   task automatic wrap_up;
      if (fail_count == 0 && comparisons > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask : wrap_up
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         fail_count++;
         $display("[FAIL] %0t got %h exp %h", $time, got, exp);
      end
   endtask : chk
   // Classic single cycle; held until ack is sampled, then released for a cycle
   task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
      @(posedge clock);
      wb_cyc_i <= 1'h1;
      wb_stb_i <= 1'h1;
      wb_we_i <= we;
      wb_adr_i <= a;
      wb_dat_i <= d;
      do @(posedge clock); while (wb_ack_o !== 1'h1);
      q = wb_dat_o;
      wb_cyc_i <= 1'h0;
      wb_stb_i <= 1'h0;
   endtask : wb
   task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
      wb(1'h0, a, 32'h0);
      chk(q & m, e);
   endtask : rd
   task automatic do_reset;
      rst <= 1'h1;
      repeat (5) @(posedge clock);
      rst <= 1'h0;
      repeat (8) @(posedge clock);
   endtask : do_reset
   task automatic jir(input logic [3:0] c);
      jisp_jtag_model_inst.scan(1'h1, {20'h0, c}, 4, r);
      repeat (24) @(posedge clock);
   endtask : jir
   task automatic jdr(input logic [23:0] v);
      jisp_jtag_model_inst.scan(1'h0, v, 24, r);
      repeat (24) @(posedge clock);
   endtask : jdr
   // ********
   // Main sequence
   // ********
   initial begin
      do_reset();
      rd(OFS_PORT_ENABLE, 32'hFFFFFFFF, 32'h0);
      rd(8'h08, 32'hFFFFFFFF, 32'h0);
      chk(jtag_pins_claimed, 1'h0);
      wb(1'h1, OFS_PORT_ENABLE, 32'hFFFFFFFF);
      rd(OFS_PORT_ENABLE, 32'hFFFFFFFF, 32'h1);
      wb(1'h1, OFS_PORT_ENABLE, 32'h0);
      rd(OFS_PORT_ENABLE, 32'h1, 32'h0);
      wb(1'h1, OFS_PORT_ENABLE, 32'h1);
      jisp_jtag_model_inst.tlr();
      chk({jtag_pins_claimed, ext_pins_claimed, tdo_oe_n, flash_status_pin_oe_n}, 4'hB);
      jir(INS_EXT_ENABLE);
      chk({ext_pins_claimed, tdo_oe_n}, 2'h2);
      fail_next = 1'h1;
      jir(INS_PROGRAM);
      jdr(24'h1234A5);
      chk({flash_op, flash_addr, flash_wdata, starts[3:0]}, {FOP_PROGRAM, 24'h1234A5, 4'h1});
      chk({program_error_flag_pin_out, program_error_flag_pin_oe_n}, 2'h0);
      jir(4'hE);
      rd(OFS_STATUS, 32'h2, 32'h2);
      jir(INS_CLR_ERROR);
      chk(program_error_flag_pin_out, 1'h1);
      fail_next = 1'h0;
      jir(INS_SECT_ERASE);
      jdr(24'h200000);
      jdr(24'hC00000);
      chk(starts, 1);
      jdr(24'h300000);
      chk({starts[3:0], flash_op}, {4'h2, FOP_SECT_ERASE});
      jir(INS_READ);
      jdr(24'h400000);
      jdr(24'h0);
      chk(r[7:0], 8'h5A);
      jir(INS_OPEN_DRAIN);
      chk({program_error_flag_pin_oe_n, flash_status_pin_oe_n}, 2'h3);
      fail_next = 1'h1;
      jir(INS_PROGRAM);
      jdr(24'h0);
      chk({program_error_flag_pin_out, program_error_flag_pin_oe_n}, 2'h0);
      fail_next = 1'h0;
      jir(INS_ISC_DISABLE);
      device_reset_n <= 1'h0;
      repeat (12) @(posedge clock);
      chk({jtag_pins_claimed, tdo_oe_n}, 2'h1);
      device_reset_n <= 1'h1;
      repeat (12) @(posedge clock);
      rd(OFS_STATUS, 32'h2, 32'h0);
      rd(OFS_PORT_ENABLE, 32'h1, 32'h0);
      pin_claim_product_term <= 1'h1;
      repeat (8) @(posedge clock);
      chk(jtag_pins_claimed, 1'h1);
      pin_claim_product_term <= 1'h0;
      nv_security <= 1'h1;
      do_reset();
      wb(1'h1, OFS_PORT_ENABLE, 32'h1);
      jisp_jtag_model_inst.tlr();
      jir(INS_ISC_ENABLE);
      rd(OFS_STATUS, 32'h1, 32'h1);
      s0 = starts;
      for (int i = 0; i < 4; i++) begin
         jir(BLOCKED[i]);
         jdr(24'h300000);
         jdr(24'h300000);
         if (i < 2) chk(r[7:0], 8'h0);
      end
      chk(starts - s0, 0);
      jir(INS_CHIP_ERASE);
      jdr(24'h0);
      chk({flash_op, starts[7:0] - s0[7:0]}, {FOP_CHIP_ERASE, 8'h1});
      rd(OFS_STATUS, 32'h1, 32'h0);
      nv_dedicate <= 1'h1;
      nv_security <= 1'h0;
      do_reset();
      device_reset_n <= 1'h0;
      jisp_jtag_model_inst.tlr();
      jir(INS_EXT_ENABLE);
      chk({jtag_pins_claimed, ext_pins_claimed}, 2'h3);
      wrap_up();
   end
endmodule : tb
bind jisp_port jisp_properties jisp_properties_inst (.*);
